// ==== rtl/psc_consts.vh ====
// Constants for the strap configuration latch: pin slots, pull defaults,
// register indices, byte addresses, field positions and reset values.
// Assumes it is included by bare name from the rtl/ directory.
//
// What this block does
// - Sample every strap pin once at reset release and keep it as configuration.
// - Strap pins are pulled inputs during reset, normal outputs once the straps have been captured.
// - Management address low three bits come from address straps, default 1.
// - Management address bits four and three are zero.
// - Address zero is broadcast unless broadcast-disable strap or control bit 9 set.
// - Broadcast-disable strap defaults low; high makes address zero unique.
// - Mode code 001 is RMII, 101 back-to-back repeater, others reserved.
// - Isolate strap loads basic control bit 10; high enables isolation.
// - Speed strap loads basic control bit 13 and advertised speed; high 100 Mbps.
// - Duplex strap loads basic control bit 8; high half duplex, low full.
// - Auto-negotiation strap loads basic control bit 12; high enables it.
// - Test-tree strap sampled at release; low enables test tree mode.
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH

`define PSC_NPINS        12
`define PSC_PIN_ADDR_LO  0
`define PSC_PIN_ADDR_HI  2
`define PSC_PIN_MODE_LO  3
`define PSC_PIN_MODE_HI  5
`define PSC_PIN_ISO      6
`define PSC_PIN_SPEED    7
`define PSC_PIN_DUPLEX   8
`define PSC_PIN_ANEG     9
`define PSC_PIN_BCAST    10
`define PSC_PIN_TTREE    11
`define PSC_PIN_PULL     12'hb81

`define PSC_ADDR_UPPER   2'h0
`define PSC_MODE_RMII    3'h1
`define PSC_MODE_B2B     3'h5

`define PSC_IDX_BCTRL    8'h00
`define PSC_IDX_ADV      8'h04
`define PSC_IDX_CTRL2    8'h16
`define PSC_IDX_STRAP    8'h20
`define PSC_ADDR_BCTRL   ({`PSC_IDX_BCTRL, 2'h0})
`define PSC_ADDR_ADV     ({`PSC_IDX_ADV, 2'h0})
`define PSC_ADDR_CTRL2   ({`PSC_IDX_CTRL2, 2'h0})
`define PSC_ADDR_STRAP   ({`PSC_IDX_STRAP, 2'h0})

`define PSC_BC_DUPLEX    8
`define PSC_BC_ISO       10
`define PSC_BC_ANEG      12
`define PSC_BC_SPEED     13
`define PSC_ADV_LO       5
`define PSC_ADV_HI       8
`define PSC_ADV_SEL      5'h01
`define PSC_ADV_100      4'hc
`define PSC_ADV_10       4'h3
`define PSC_C2_BCOFF     9

`define PSC_HTRANS_NSEQ  2'h2
`define PSC_HSIZE_WORD   3'h2
`define PSC_ZERO32       32'h0000_0000

`endif

// ==== rtl/psc_reset_sync.v ====
// Reset release synchroniser for the strap latch.
// Assumes rstn may drop at any time and must be released cleanly to refClk.
`timescale 1ns/1ps
module psc_reset_sync (
   // Clock and raw reset
   input  wire ref_clk,
   input  wire rstn,
   // Synchronised reset
   output wire rstSyncN
);
   reg stage1;
   reg stage2;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= 1'b1;
         stage2 <= stage1;
      end
   end

   assign rstSyncN = stage2;
endmodule

// ==== rtl/psc_strap_pad.v ====
// Direction control for the shared strap / function pins.
// Assumes the board resolves each wire from the output enables and pulls.
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_strap_pad (
   // Clock and reset
   input  wire                    ref_clk,
   input  wire                    rstSyncN,
   // Pin role
   input  wire                    driveEn,
   input  wire [`PSC_NPINS-1:0]   funcOut,
   // Pin side
   output wire [`PSC_NPINS-1:0]   strapOut,
   output wire [`PSC_NPINS-1:0]   strapOeN,
   output wire [`PSC_NPINS-1:0]   strapPullOn
);
   genvar i;
   generate
      for (i = 0; i < `PSC_NPINS; i = i + 1) begin : gPin
         reg outBit;
         reg oeNBit;
         // Driving stays off until the level has been captured, so the
         // sample always sees the board strap rather than our own output.
         always @(posedge ref_clk or negedge rstSyncN) begin
            if (!rstSyncN) begin
               outBit <= 1'b0;
               oeNBit <= 1'b1;
            end else begin
               outBit <= driveEn ? funcOut[i] : 1'b0;
               oeNBit <= ~driveEn;
            end
         end
         assign strapOut[i]    = outBit;
         assign strapOeN[i]    = oeNBit;
         assign strapPullOn[i] = oeNBit;
      end
   endgenerate
endmodule

// ==== rtl/psc_strap_config_latch.v ====
// Strap configuration latch with an AHB-Lite register slave.
// Assumes strap inputs are synchronous to ref_clk and held stable by the
// board through reset release; a single AHB-Lite master drives the bus.
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_strap_config_latch (
   // Clock and reset
   input  wire                    ref_clk,
   input  wire                    rstn,
   // AHB-Lite slave
   input  wire                    hsel,
   input  wire [31:0]             haddr,
   input  wire [1:0]              htrans,
   input  wire                    hwrite,
   input  wire [2:0]              hsize,
   input  wire [31:0]             hwdata,
   input  wire                    hready,
   output wire                    hreadyout,
   output wire                    hresp,
   output reg  [31:0]             hrdata,
   // Strap pins
   input  wire [`PSC_NPINS-1:0]   strapIn,
   output wire [`PSC_NPINS-1:0]   strapOut,
   output wire [`PSC_NPINS-1:0]   strapOeN,
   output wire [`PSC_NPINS-1:0]   strapPullOn,
   // Normal pin functions after reset
   input  wire [`PSC_NPINS-1:0]   funcOut,
   // Configuration to the transceiver
   output reg  [4:0]              mgmtAddr,
   output reg                     bcastAddrZero,
   output reg  [2:0]              ifMode,
   output reg                     rmiiMode,
   output reg                     backToBack,
   output reg                     modeReserved,
   output reg                     isolateEn,
   output reg                     speed100,
   output reg                     duplexBit,
   output reg                     autonegEn,
   output reg  [3:0]              advCaps,
   output reg                     testTreeEn,
   output reg                     strapsValid
);
   localparam [2:0] ST_HOLD   = 3'h1;
   localparam [2:0] ST_SAMPLE = 3'h2;
   localparam [2:0] ST_RUN    = 3'h4;

   wire        rstSyncN;
   reg  [2:0]  state;
   reg  [2:0]  next_state;
   wire        capture;

   // Latched straps
   reg  [2:0]  addrStrap;
   reg  [2:0]  modeStrap;
   reg         bcastStrap;
   reg         ttreeStrap;

   // Software-visible register bits
   reg         bcIso;
   reg         bcSpeed;
   reg         bcDuplex;
   reg         bcAneg;
   reg  [3:0]  adv;
   reg         c2BcOff;
   reg         next_bcIso;
   reg         next_bcSpeed;
   reg         next_bcDuplex;
   reg         next_bcAneg;
   reg  [3:0]  next_adv;
   reg         next_c2BcOff;

   // Bus pipeline
   reg         wrPend;
   reg  [9:0]  wrAddr;
   wire        addrPhase;
   wire        rdReq;
   wire        wrReq;
   wire        wrNow;
   reg  [31:0] rdValue;

   function regHit;
      input [9:0] addr;
      input [9:0] regAddr;
      begin
         regHit = (addr == regAddr);
      end
   endfunction

   function [31:0] readMux;
      input [9:0] addr;
      input       iso;
      input       spd;
      input       dup;
      input       aneg;
      input [3:0] caps;
      input       bcoff;
      input [11:0] strapStat;
      begin
         readMux = `PSC_ZERO32;
         if (regHit(addr, `PSC_ADDR_BCTRL)) begin
            readMux[`PSC_BC_SPEED]  = spd;
            readMux[`PSC_BC_ANEG]   = aneg;
            readMux[`PSC_BC_ISO]    = iso;
            readMux[`PSC_BC_DUPLEX] = dup;
         end else if (regHit(addr, `PSC_ADDR_ADV)) begin
            readMux[`PSC_ADV_HI:`PSC_ADV_LO] = caps;
            readMux[4:0] = `PSC_ADV_SEL;
         end else if (regHit(addr, `PSC_ADDR_CTRL2)) begin
            readMux[`PSC_C2_BCOFF] = bcoff;
         end else if (regHit(addr, `PSC_ADDR_STRAP)) begin
            readMux[11:0] = strapStat;
         end
      end
   endfunction

   psc_reset_sync uSync (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .rstSyncN (rstSyncN)
   );

   psc_strap_pad uPad (
      .ref_clk     (ref_clk),
      .rstSyncN    (rstSyncN),
      .driveEn     (state == ST_RUN),
      .funcOut     (funcOut),
      .strapOut    (strapOut),
      .strapOeN    (strapOeN),
      .strapPullOn (strapPullOn)
   );

   // The board's straps are only trusted while nothing drives the nets;
   // an attached MAC must stay off them or the board must out-pull it.
   always @* begin
      next_state = state;
      case (state)
         ST_HOLD:   next_state = ST_SAMPLE;
         ST_SAMPLE: next_state = ST_RUN;
         ST_RUN:    next_state = ST_RUN;
         default:   next_state = ST_HOLD;
      endcase
   end

   assign capture = (state == ST_SAMPLE);

   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state <= ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // Strap capture; reset values mirror the internal pulls.
   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         addrStrap  <= 3'h1;
         modeStrap  <= 3'h0;
         bcastStrap <= 1'b0;
         ttreeStrap <= 1'b1;
      end else if (capture) begin
         addrStrap  <= strapIn[`PSC_PIN_ADDR_HI:`PSC_PIN_ADDR_LO];
         modeStrap  <= strapIn[`PSC_PIN_MODE_HI:`PSC_PIN_MODE_LO];
         bcastStrap <= strapIn[`PSC_PIN_BCAST];
         ttreeStrap <= strapIn[`PSC_PIN_TTREE];
      end
   end

   // AHB-Lite: zero wait states, always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addrPhase = hsel && hready && (htrans == `PSC_HTRANS_NSEQ);
   assign rdReq     = addrPhase && !hwrite;
   assign wrReq     = addrPhase && hwrite && (hsize == `PSC_HSIZE_WORD);
   // Writes that would land during the capture cycle are dropped so the
   // strapped value is never lost to a racing write.
   assign wrNow     = wrPend && (state == ST_RUN);

   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         wrPend <= 1'b0;
         wrAddr <= 10'h000;
      end else begin
         wrPend <= wrReq;
         wrAddr <= haddr[9:0];
      end
   end

   always @* begin
      next_bcIso    = bcIso;
      next_bcSpeed  = bcSpeed;
      next_bcDuplex = bcDuplex;
      next_bcAneg   = bcAneg;
      next_adv      = adv;
      next_c2BcOff  = c2BcOff;
      if (capture) begin
         next_bcIso    = strapIn[`PSC_PIN_ISO];
         next_bcSpeed  = strapIn[`PSC_PIN_SPEED];
         next_adv      = strapIn[`PSC_PIN_SPEED] ? `PSC_ADV_100 : `PSC_ADV_10;
         next_bcDuplex = strapIn[`PSC_PIN_DUPLEX];
         next_bcAneg   = strapIn[`PSC_PIN_ANEG];
      end else if (wrNow) begin
         // Only software changes these after capture.
         if (regHit(wrAddr, `PSC_ADDR_BCTRL)) begin
            next_bcIso    = hwdata[`PSC_BC_ISO];
            next_bcSpeed  = hwdata[`PSC_BC_SPEED];
            next_bcDuplex = hwdata[`PSC_BC_DUPLEX];
            next_bcAneg   = hwdata[`PSC_BC_ANEG];
         end
         if (regHit(wrAddr, `PSC_ADDR_ADV)) begin
            next_adv = hwdata[`PSC_ADV_HI:`PSC_ADV_LO];
         end
         if (regHit(wrAddr, `PSC_ADDR_CTRL2)) begin
            next_c2BcOff = hwdata[`PSC_C2_BCOFF];
         end
      end
   end

   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         bcIso    <= 1'b0;
         bcSpeed  <= 1'b1;
         bcDuplex <= 1'b1;
         bcAneg   <= 1'b1;
         adv      <= `PSC_ADV_100;
         c2BcOff  <= 1'b0;
      end else begin
         bcIso    <= next_bcIso;
         bcSpeed  <= next_bcSpeed;
         bcDuplex <= next_bcDuplex;
         bcAneg   <= next_bcAneg;
         adv      <= next_adv;
         c2BcOff  <= next_c2BcOff;
      end
   end

   // Reads see the post-write value, so a read straight after a write to
   // the same register needs no wait state.
   always @* begin
      rdValue = readMux(haddr[9:0], next_bcIso, next_bcSpeed, next_bcDuplex,
                        next_bcAneg, next_adv, next_c2BcOff,
                        {2'h0, ttreeStrap, bcastStrap, modeStrap, addrStrap,
                         (state == ST_RUN), modeReserved});
   end

   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         hrdata <= `PSC_ZERO32;
      end else if (rdReq) begin
         hrdata <= rdValue;
      end
   end

   // Registered configuration outputs, one cycle behind the registers.
   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         mgmtAddr      <= 5'h01;
         bcastAddrZero <= 1'b1;
         ifMode        <= 3'h0;
         rmiiMode      <= 1'b0;
         backToBack    <= 1'b0;
         modeReserved  <= 1'b1;
         isolateEn     <= 1'b0;
         speed100      <= 1'b1;
         duplexBit     <= 1'b1;
         autonegEn     <= 1'b1;
         advCaps       <= `PSC_ADV_100;
         testTreeEn    <= 1'b0;
         strapsValid   <= 1'b0;
      end else begin
         mgmtAddr      <= {`PSC_ADDR_UPPER, addrStrap};
         bcastAddrZero <= !(bcastStrap || c2BcOff);
         ifMode        <= modeStrap;
         rmiiMode      <= (modeStrap == `PSC_MODE_RMII);
         backToBack    <= (modeStrap == `PSC_MODE_B2B);
         modeReserved  <= (modeStrap != `PSC_MODE_RMII) &&
                          (modeStrap != `PSC_MODE_B2B);
         isolateEn     <= bcIso;
         speed100      <= bcSpeed;
         duplexBit     <= bcDuplex;
         autonegEn     <= bcAneg;
         advCaps       <= adv;
         testTreeEn    <= !ttreeStrap;
         strapsValid   <= (state == ST_RUN);
      end
   end
endmodule

// ==== verification/psc_strap_monitor.sv ====
// Checker for the strap latch: pin roles, capture at reset release and hold after it.
// Assumes it is bound into the latch top and sees only that module's ports.
`timescale 1ns/1ps
module psc_strap_monitor (
   // Clock and reset
   input logic        ref_clk,
   input logic        rstn,
   // Strap pins
   input logic [11:0] strapIn,
   input logic [11:0] strapOut,
   input logic [11:0] strapOeN,
   input logic [11:0] strapPullOn,
   input logic [11:0] funcOut,
   // Configuration
   input logic [4:0]  mgmtAddr,
   input logic        bcastAddrZero,
   input logic [2:0]  ifMode,
   input logic        rmiiMode,
   input logic        backToBack,
   input logic        modeReserved,
   input logic        isolateEn,
   input logic        speed100,
   input logic        duplexBit,
   input logic        autonegEn,
   input logic [3:0]  advCaps,
   input logic        testTreeEn,
   input logic        strapsValid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_pins_in;
      !strapsValid |-> strapOeN == 12'hfff && strapPullOn == 12'hfff;
   endproperty
   a_pins_in: assert property (p_pins_in) else $error("strap pin driven before capture");
   property p_pins_out;
      strapsValid |-> strapOeN == 12'h000 && strapPullOn == 12'h000;
   endproperty
   a_pins_out: assert property (p_pins_out) else $error("strap pin not driving after capture");
   property p_out_follow;
      strapsValid && $past(strapsValid) |-> strapOut == $past(funcOut);
   endproperty
   a_out_follow: assert property (p_out_follow) else $error("pin output not from function");
   property p_cap_addr;
      $rose(strapsValid) |-> mgmtAddr == {2'h0, $past(strapIn[2:0], 2)};
   endproperty
   a_cap_addr: assert property (p_cap_addr) else $error("address not captured");
   property p_addr_up;
      mgmtAddr[4:3] == 2'h0;
   endproperty
   a_addr_up: assert property (p_addr_up) else $error("upper address bits not zero");
   property p_cap_mode;
      $rose(strapsValid) |-> ifMode == $past(strapIn[5:3], 2) && testTreeEn == !$past(strapIn[11], 2);
   endproperty
   a_cap_mode: assert property (p_cap_mode) else $error("mode or test tree not captured");
   property p_mode_dec;
      strapsValid |-> rmiiMode == (ifMode == 3'h1) && backToBack == (ifMode == 3'h5)
         && modeReserved == !(ifMode == 3'h1 || ifMode == 3'h5);
   endproperty
   a_mode_dec: assert property (p_mode_dec) else $error("mode decode wrong");
   property p_cap_ctrl;
      $rose(strapsValid) |-> isolateEn == $past(strapIn[6], 2) && speed100 == $past(strapIn[7], 2)
         && duplexBit == $past(strapIn[8], 2) && autonegEn == $past(strapIn[9], 2)
         && bcastAddrZero == !$past(strapIn[10], 2);
   endproperty
   a_cap_ctrl: assert property (p_cap_ctrl) else $error("control straps not captured");
   property p_adv;
      $rose(strapsValid) |-> advCaps == (speed100 ? 4'hc : 4'h3);
   endproperty
   a_adv: assert property (p_adv) else $error("advertised speed wrong");
   property p_hold;
      strapsValid && $past(strapsValid) |-> $stable(mgmtAddr) && $stable(ifMode) && $stable(testTreeEn);
   endproperty
   a_hold: assert property (p_hold) else $error("strapped value moved after capture");
endmodule

bind psc_strap_config_latch psc_strap_monitor u_mon (.ref_clk, .rstn, .strapIn, .strapOut,
   .strapOeN, .strapPullOn, .funcOut, .mgmtAddr, .bcastAddrZero, .ifMode, .rmiiMode,
   .backToBack, .modeReserved, .isolateEn, .speed100, .duplexBit, .autonegEn, .advCaps,
   .testTreeEn, .strapsValid);

// ==== verification/psc_board_model.sv ====
// Board side of the strap pins: resistors, internal pulls and the device's own drive.
// Assumes the attached MAC stays off the shared nets while reset is active.
`timescale 1ns/1ps
module psc_board_model (
   // Clock
   input logic        ref_clk,
   // Device pad side
   input logic [11:0] strapOut,
   input logic [11:0] strapOeN,
   input logic [11:0] strapPullOn,
   // Board straps
   input logic [11:0] boardEn,
   input logic [11:0] boardVal,
   // Resolved pin levels
   output logic [11:0] pinLevel
);
   // Internal pull directions of the pads: ones are pull-ups.
   localparam logic [11:0] PULL_UP = 12'hb81;
   logic [11:0] lastLevel = 12'h000;
   integer      i;

   always @(posedge ref_clk) begin
      lastLevel <= pinLevel;
   end

   // A floating net shows the inverse of its last level so no stale value passes.
   always @* begin
      for (i = 0; i < 12; i = i + 1) begin
         if (!strapOeN[i]) begin
            pinLevel[i] = strapOut[i];
         end else if (boardEn[i]) begin
            pinLevel[i] = boardVal[i];
         end else if (strapPullOn[i]) begin
            pinLevel[i] = PULL_UP[i];
         end else begin
            pinLevel[i] = ~lastLevel[i];
         end
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the strap latch: strap capture, register access, pin roles.
// Assumes the board model resolves the pins and the monitor is bound into the top.
`timescale 1ns/1ps
`include "psc_consts.vh"
module tb_top;
   logic        ref_clk;
   logic        rstn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hready, hreadyout, hresp, rmiiMode, backToBack, modeReserved, isolateEn;
   logic        speed100, duplexBit, autonegEn, testTreeEn, strapsValid, bcastAddrZero;
   logic [31:0] hrdata, rd;
   logic [11:0] strapIn, strapOut, strapOeN, strapPullOn, s;
   logic [11:0] funcOut = 12'h5a6;
   logic [11:0] boardEn = 12'h000;
   logic [11:0] boardVal = 12'h000;
   logic [4:0]  mgmtAddr;
   logic [2:0]  ifMode;
   logic [3:0]  advCaps;
   int          n_fail = 0;
   int          total_checks = 0;

   assign hready = hreadyout;
   psc_strap_config_latch dut (.ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .strapIn, .strapOut, .strapOeN,
      .strapPullOn, .funcOut, .mgmtAddr, .bcastAddrZero, .ifMode, .rmiiMode, .backToBack,
      .modeReserved, .isolateEn, .speed100, .duplexBit, .autonegEn, .advCaps, .testTreeEn,
      .strapsValid);
   psc_board_model board (.ref_clk, .strapOut, .strapOeN, .strapPullOn, .boardEn, .boardVal,
      .pinLevel(strapIn));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // The normal pin functions keep changing so a late re-capture would show.
   always @(posedge ref_clk) begin
      funcOut <= funcOut + 12'h2d3;
   end

   task automatic results;
      if (n_fail == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic waitRdy;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         n_fail++;
         results();
      end
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [2:0] sz);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= `PSC_HTRANS_NSEQ;
      hwrite <= w;
      hsize <= sz;
      waitRdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      rd = hrdata;
   endtask

   task automatic boot(input logic [11:0] en, input logic [11:0] sv);
      int n;
      boardEn <= en;
      boardVal <= sv;
      rstn <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({strapOeN, strapPullOn}, 32'h00ff_ffff);
      rstn <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (strapsValid !== 1'b1 && n < 20);
      if (strapsValid !== 1'b1) begin
         n_fail++;
         results();
      end
      boardVal <= ~sv;
   endtask

   task automatic cfg(input logic [11:0] sv);
      logic [2:0] m;
      logic       rsv;
      m = sv[5:3];
      rsv = m != `PSC_MODE_RMII && m != `PSC_MODE_B2B;
      chk(mgmtAddr, {2'h0, sv[2:0]});
      chk({rmiiMode, backToBack, modeReserved, ifMode}, {m == 3'h1, m == 3'h5, rsv, m});
      chk({isolateEn, speed100, duplexBit, autonegEn}, {sv[6], sv[7], sv[8], sv[9]});
      chk({advCaps, bcastAddrZero, testTreeEn}, {sv[7] ? 4'hc : 4'h3, !sv[10], !sv[11]});
      chk(strapOeN, 12'h000);
      chk({hresp, hreadyout}, 32'h0000_0001);
      xfer(1'b0, `PSC_ADDR_BCTRL, 32'h0000_0000, `PSC_HSIZE_WORD);
      chk(rd, {sv[7], sv[9], 1'b0, sv[6], 1'b0, sv[8], 8'h00});
      xfer(1'b0, `PSC_ADDR_ADV, 32'h0000_0000, `PSC_HSIZE_WORD);
      chk(rd, {sv[7] ? 4'hc : 4'h3, 5'h01});
      xfer(1'b0, `PSC_ADDR_STRAP, 32'h0000_0000, `PSC_HSIZE_WORD);
      chk(rd, {sv[11], sv[10], m, sv[2:0], 1'b1, rsv});
   endtask

   initial begin
      boot(12'h000, 12'h000);
      chk(mgmtAddr, 5'h01);
      cfg(12'hb81);
      xfer(1'b1, `PSC_ADDR_CTRL2, 32'h0000_0200, `PSC_HSIZE_WORD);
      xfer(1'b0, `PSC_ADDR_CTRL2, 32'h0000_0000, `PSC_HSIZE_WORD);
      chk(rd, 32'h0000_0200);
      chk(bcastAddrZero, 1'b0);
      xfer(1'b1, `PSC_ADDR_BCTRL, 32'h0000_0400, `PSC_HSIZE_WORD);
      xfer(1'b1, `PSC_ADDR_BCTRL, 32'h0000_3100, 3'h0);
      xfer(1'b0, `PSC_ADDR_BCTRL, 32'h0000_0000, `PSC_HSIZE_WORD);
      chk(rd, 32'h0000_0400);
      chk({isolateEn, speed100, duplexBit, autonegEn}, 4'h8);
      xfer(1'b1, 32'h0000_0200, 32'hffff_ffff, `PSC_HSIZE_WORD);
      xfer(1'b0, 32'h0000_0200, 32'h0000_0000, `PSC_HSIZE_WORD);
      chk(rd, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         s = {4{i[2:0]}};
         boot(12'hfff, s);
         cfg(s);
         xfer(1'b1, `PSC_ADDR_STRAP, 32'h0000_0000, `PSC_HSIZE_WORD);
         cfg(s);
      end
      results();
   end
endmodule
